// ### design/drsio_port.v
// sram port core: pin sampling, command capture, array access, ddr output
`timescale 1ns/1ps
`include "drsio_defines.vh"
module drsio_port #(
    parameter AW = `DRSIO_ADDR_W,
    parameter DW = `DRSIO_DATA_W,
    parameter CAL_PERIOD = `DRSIO_CAL_PERIOD
) (
    // core clock, reset, enable
    input wire core_clk_in,
    input wire nrst_in,
    input wire ce_in,
    // input clock pair
    input wire k_clk_in,
    input wire k_clk_n_in,
    // output clock pair
    input wire c_clk_in,
    input wire c_clk_n_in,
    input wire dll_off_n_in,
    // command and write data
    input wire load_strobe_n_in,
    input wire read_write_sel_in,
    input wire [AW-1:0] address_in,
    input wire [1:0] byte_write_sel_n_in,
    input wire [DW-1:0] wr_data_in,
    // read data and echo clocks
    output reg [DW-1:0] rd_data_out,
    output reg rd_data_oe_out,
    output reg echo_clock_pos_out,
    output reg echo_clock_neg_out,
    // impedance calibration strobe
    output reg impedance_cal_out
);
    localparam BW = 2 * DW;
    localparam ST_IDLE = 3'b001;
    localparam ST_WORD0 = 3'b010;
    localparam ST_WORD1 = 3'b100;

    // three-stage samplers; a change counts once stages two and three agree
    reg [`DRSIO_SYNC_W-1:0] k_s_q, kn_s_q, c_s_q, cn_s_q;
    reg k_q, kn_q, c_q, cn_q;
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            k_s_q <= 3'h0;
            kn_s_q <= 3'h0;
            c_s_q <= 3'h0;
            cn_s_q <= 3'h0;
            k_q <= 1'b0;
            kn_q <= 1'b0;
            c_q <= 1'b0;
            cn_q <= 1'b0;
        end else if (ce_in) begin
            k_s_q <= {k_s_q[1:0], k_clk_in};
            kn_s_q <= {kn_s_q[1:0], k_clk_n_in};
            c_s_q <= {c_s_q[1:0], c_clk_in};
            cn_s_q <= {cn_s_q[1:0], c_clk_n_in};
            if (k_s_q[1] == k_s_q[2]) k_q <= k_s_q[2];
            if (kn_s_q[1] == kn_s_q[2]) kn_q <= kn_s_q[2];
            if (c_s_q[1] == c_s_q[2]) c_q <= c_s_q[2];
            if (cn_s_q[1] == cn_s_q[2]) cn_q <= cn_s_q[2];
        end
    end
    wire k_stable = (k_s_q[1] == k_s_q[2]);
    wire kn_stable = (kn_s_q[1] == kn_s_q[2]);
    wire c_stable = (c_s_q[1] == c_s_q[2]);
    wire cn_stable = (cn_s_q[1] == cn_s_q[2]);
    wire k_rise = k_stable && k_s_q[2] && !k_q;
    wire kn_rise = kn_stable && kn_s_q[2] && !kn_q;
    wire c_rise = c_stable && c_s_q[2] && !c_q;
    wire cn_rise = cn_stable && cn_s_q[2] && !cn_q;

    // pins are sampled through two stages, one fewer than the clocks
    reg [AW+DW+4-1:0] pin_s1_q, pin_s2_q;
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            // idle pins read as load high so no command leaks out of reset
            pin_s1_q <= {(AW+DW+4){1'b1}};
            pin_s2_q <= {(AW+DW+4){1'b1}};
        end else if (ce_in) begin
            pin_s1_q <= {load_strobe_n_in, read_write_sel_in, byte_write_sel_n_in,
                         address_in, wr_data_in};
            pin_s2_q <= pin_s1_q;
        end
    end
    wire p_ld_n = pin_s2_q[AW+DW+3];
    wire p_rw = pin_s2_q[AW+DW+2];
    wire [1:0] p_bw_n = pin_s2_q[AW+DW+1:AW+DW];
    wire [AW-1:0] p_addr = pin_s2_q[AW+DW-1:DW];
    wire [DW-1:0] p_data = pin_s2_q[DW-1:0];

    // single clock mode when both output clocks sit high
    wire single_clk = c_q && cn_q;
    wire out_rise_p = single_clk ? k_rise : c_rise;
    wire out_rise_n = single_clk ? kn_rise : cn_rise;

    // write state: address on k, word0 on next k, word1 on following k-bar
    reg [2:0] wst_q;
    reg [AW-1:0] waddr_q;
    reg [DW-1:0] w0_q;
    reg [1:0] bw0_n_q;
    reg wr_go_q;
    reg [BW-1:0] wdata_q;
    reg [3:0] wlane_q;
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            wst_q <= ST_IDLE;
            waddr_q <= {AW{1'b0}};
            w0_q <= {DW{1'b0}};
            bw0_n_q <= 2'h3;
            wr_go_q <= 1'b0;
            wdata_q <= {BW{1'b0}};
            wlane_q <= 4'h0;
        end else if (ce_in) begin
            wr_go_q <= 1'b0;
            case (wst_q)
                ST_WORD0: begin
                    if (k_rise) begin
                        w0_q <= p_data;
                        bw0_n_q <= p_bw_n;
                        wst_q <= ST_WORD1;
                    end
                end
                ST_WORD1: begin
                    if (kn_rise) begin
                        wdata_q <= {p_data, w0_q};
                        // low lane bits 8..0, high lane bits 17..9
                        wlane_q <= ~{p_bw_n, bw0_n_q};
                        wr_go_q <= 1'b1;
                        wst_q <= ST_IDLE;
                    end
                end
                default: begin
                    wst_q <= ST_IDLE;
                end
            endcase
            // a new command is taken only on k rise with load low
            if (k_rise && !p_ld_n && !p_rw) begin
                waddr_q <= p_addr;
                wst_q <= ST_WORD0;
            end
        end
    end

    // read launch: one per k rise, never together with a write
    wire rd_go = k_rise && !p_ld_n && p_rw;
    wire [BW-1:0] rdata;
    reg rd_pend_q;
    always @(posedge core_clk_in) begin
        if (!nrst_in) rd_pend_q <= 1'b0;
        else if (ce_in) rd_pend_q <= rd_go;
    end

    drsio_mem #(
        .AW(AW),
        .DW(BW),
        .LW(`DRSIO_LANE_W),
        .NL(4)
    ) u_mem (
        .clk_in(core_clk_in),
        .ce_in(ce_in),
        .wr_en_in(wr_go_q),
        .wr_addr_in(waddr_q),
        .wr_data_in(wdata_q),
        .wr_lane_in(wlane_q),
        .rd_en_in(rd_go),
        .rd_addr_in(p_addr),
        .rd_data_out(rdata)
    );

    // buffer holds read bursts until the output edges drain them: the c pair, or the k pair in single clock mode
    wire buf_in_ready;
    wire buf_valid;
    wire [BW-1:0] buf_data;
    reg drain_q;
    drsio_buf2 #(
        .W(BW)
    ) u_buf (
        .clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .in_valid_in(rd_pend_q),
        .in_ready_out(buf_in_ready),
        .in_data_in(rdata),
        .out_valid_out(buf_valid),
        .out_ready_in(drain_q),
        .out_data_out(buf_data)
    );

    // output sequencer: word0 on out rise, word1 on out-bar rise
    // latency is fixed by the output edges (c pair, or k pair in single clock mode); dll bypass is registered but adds no stage
    reg [1:0] ost_q;
    reg [DW-1:0] hold1_q;
    reg dll_n_q;
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            ost_q <= 2'h0;
            hold1_q <= {DW{1'b0}};
            drain_q <= 1'b0;
            rd_data_out <= {DW{1'b0}};
            rd_data_oe_out <= 1'b0;
            echo_clock_pos_out <= 1'b0;
            echo_clock_neg_out <= 1'b1;
            dll_n_q <= 1'b1;
        end else if (ce_in) begin
            dll_n_q <= dll_off_n_in;
            drain_q <= 1'b0;
            if (out_rise_p) begin
                echo_clock_pos_out <= 1'b1;
                echo_clock_neg_out <= 1'b0;
                if (buf_valid && !drain_q) begin
                    rd_data_out <= buf_data[DW-1:0];
                    hold1_q <= buf_data[BW-1:DW];
                    rd_data_oe_out <= 1'b1;
                    drain_q <= 1'b1;
                    ost_q <= 2'h1;
                end else begin
                    rd_data_oe_out <= 1'b0;
                    ost_q <= 2'h0;
                end
            end else if (out_rise_n) begin
                echo_clock_neg_out <= 1'b1;
                echo_clock_pos_out <= 1'b0;
                if (ost_q == 2'h1) begin
                    rd_data_out <= hold1_q;
                    ost_q <= 2'h2;
                end else begin
                    rd_data_oe_out <= 1'b0;
                end
            end
        end
    end

    // periodic impedance recalibration strobe
    reg [`DRSIO_CAL_W-1:0] cal_cnt_q;
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            cal_cnt_q <= {`DRSIO_CAL_W{1'b0}};
            impedance_cal_out <= 1'b0;
        end else if (ce_in) begin
            impedance_cal_out <= 1'b0;
            if (cal_cnt_q == CAL_PERIOD - 1) begin
                cal_cnt_q <= {`DRSIO_CAL_W{1'b0}};
                impedance_cal_out <= 1'b1;
            end else begin
                cal_cnt_q <= cal_cnt_q + 1'b1;
            end
        end
    end
endmodule // drsio_port

// ### design/drsio_defines.vh
// shared constants for the dual rate split io sram port
`ifndef DRSIO_DEFINES_VH
`define DRSIO_DEFINES_VH
`define DRSIO_ADDR_W 19
`define DRSIO_DATA_W 18
`define DRSIO_LANE_W 9
`define DRSIO_LO_LSB 0
`define DRSIO_HI_LSB 9
`define DRSIO_READ_LAT 2
`define DRSIO_CAL_PERIOD 1024
`define DRSIO_CAL_W 10
`define DRSIO_SYNC_W 3
`endif

// ### design/drsio_mem.v
// burst-wide storage array with per-lane write enables and registered read
`timescale 1ns/1ps
module drsio_mem #(
    parameter AW = 19,
    parameter DW = 36,
    parameter LW = 9,
    parameter NL = 4
) (
    // clock
    input wire clk_in,
    input wire ce_in,
    // write side
    input wire wr_en_in,
    input wire [AW-1:0] wr_addr_in,
    input wire [DW-1:0] wr_data_in,
    input wire [NL-1:0] wr_lane_in,
    // read side
    input wire rd_en_in,
    input wire [AW-1:0] rd_addr_in,
    output reg [DW-1:0] rd_data_out
);
    reg [DW-1:0] mem_q [0:(1<<AW)-1];
    integer i;
    always @(posedge clk_in) begin
        if (ce_in) begin
            if (rd_en_in) begin
                rd_data_out <= mem_q[rd_addr_in];
            end
            if (wr_en_in) begin
                for (i = 0; i < NL; i = i + 1) begin
                    // unselected lanes keep old contents
                    if (wr_lane_in[i]) begin
                        mem_q[wr_addr_in][i*LW +: LW] <= wr_data_in[i*LW +: LW];
                    end
                end
            end
        end
    end
endmodule // drsio_mem

// ### design/drsio_buf2.v
// two-entry valid/ready buffer on the read data path
`timescale 1ns/1ps
module drsio_buf2 #(
    parameter W = 36
) (
    // clock and reset
    input wire clk_in,
    input wire nrst_in,
    input wire ce_in,
    // fill side
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [W-1:0] in_data_in,
    // drain side
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [W-1:0] out_data_out
);
    reg [W-1:0] slot0_q;
    reg [W-1:0] slot1_q;
    reg [1:0] count_q;
    wire push = in_valid_in && (count_q != 2'h2);
    wire pop = out_ready_in && (count_q != 2'h0);
    assign in_ready_out = (count_q != 2'h2);
    assign out_valid_out = (count_q != 2'h0);
    assign out_data_out = slot0_q;
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            count_q <= 2'h0;
            slot0_q <= {W{1'b0}};
            slot1_q <= {W{1'b0}};
        end else if (ce_in) begin
            case ({push, pop})
                2'b10: begin
                    if (count_q == 2'h0) slot0_q <= in_data_in;
                    else slot1_q <= in_data_in;
                    count_q <= count_q + 2'h1;
                end
                2'b01: begin
                    slot0_q <= slot1_q;
                    count_q <= count_q - 2'h1;
                end
                2'b11: begin
                    if (count_q == 2'h1) slot0_q <= in_data_in;
                    else begin
                        slot0_q <= slot1_q;
                        slot1_q <= in_data_in;
                    end
                end
                default: begin
                    count_q <= count_q;
                end
            endcase
        end
    end
endmodule // drsio_buf2

// ### test/drsio_port_asserts.sv
// concurrent checks on the sram port core outputs
`timescale 1ns/1ps
module drsio_port_chk #(
    parameter DW = 18,
    parameter CAL_PERIOD = 1024
) (
    // clock and reset
    input wire core_clk_in,
    input wire nrst_in,
    // clock and command pins
    input wire k_clk_in,
    input wire c_clk_in,
    input wire c_clk_n_in,
    input wire load_strobe_n_in,
    input wire read_write_sel_in,
    // outputs
    input wire [DW-1:0] rd_data_out,
    input wire rd_data_oe_out,
    input wire echo_clock_pos_out,
    input wire echo_clock_neg_out,
    input wire impedance_cal_out
);
    reg [15:0] cal_cnt_q;
    reg cal_seen_q;
    reg [7:0] rd_win_q;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    // window is loose: sync, buffer and two output edges
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            cal_cnt_q <= 16'h0000;
            cal_seen_q <= 1'b0;
            rd_win_q <= 8'h00;
        end else begin
            cal_cnt_q <= impedance_cal_out ? 16'h0000 : cal_cnt_q + 16'h0001;
            cal_seen_q <= cal_seen_q | impedance_cal_out;
            if (!load_strobe_n_in && read_write_sel_in)
                rd_win_q <= 8'h30;
            else if (rd_win_q != 8'h00)
                rd_win_q <= rd_win_q - 8'h01;
        end
    end
    property p_compl; echo_clock_pos_out != echo_clock_neg_out; endproperty
    a_compl: assert property (p_compl) else $error("echo pair equal");
    property p_live; nrst_in |-> ##[1:16] $changed(echo_clock_pos_out); endproperty
    a_live: assert property (p_live) else $error("echo stopped");
    property p_single;
        c_clk_in && c_clk_n_in && $rose(k_clk_in) |-> ##[1:8] $rose(echo_clock_pos_out);
    endproperty
    a_single: assert property (p_single) else $error("echo not on k");
    property p_first; $rose(rd_data_oe_out) |-> echo_clock_pos_out; endproperty
    a_first: assert property (p_first) else $error("word0 off edge");
    property p_hold;
        rd_data_oe_out && $changed(rd_data_out) |-> $changed(echo_clock_pos_out);
    endproperty
    a_hold: assert property (p_hold) else $error("data moved off edge");
    property p_win; rd_data_oe_out |-> rd_win_q != 8'h00; endproperty
    a_win: assert property (p_win) else $error("driven without read");
    property p_rst; $rose(nrst_in) |-> !rd_data_oe_out && echo_clock_neg_out; endproperty
    a_rst: assert property (p_rst) else $error("not idle at reset");
    property p_cal; impedance_cal_out && cal_seen_q |-> cal_cnt_q == CAL_PERIOD - 1; endproperty
    a_cal: assert property (p_cal) else $error("cal spacing wrong");
endmodule // drsio_port_chk

bind drsio_port drsio_port_chk #(.DW(DW), .CAL_PERIOD(CAL_PERIOD)) u_chk (
    .core_clk_in, .nrst_in, .k_clk_in, .c_clk_in, .c_clk_n_in,
    .load_strobe_n_in, .read_write_sel_in, .rd_data_out, .rd_data_oe_out,
    .echo_clock_pos_out, .echo_clock_neg_out, .impedance_cal_out
);

// ### test/drsio_ctrl_model.sv
// memory controller model: clock pairs, commands and write bursts
`timescale 1ns/1ps
module drsio_ctrl_model #(
    parameter AW = 8
) (
    // clock pairs
    output reg k_clk_out,
    output wire k_clk_n_out,
    output wire c_clk_out,
    output wire c_clk_n_out,
    output reg dll_off_n_out,
    // command and write data
    output reg load_strobe_n_out,
    output reg read_write_sel_out,
    output reg [AW-1:0] address_out,
    output reg [1:0] byte_write_sel_n_out,
    output reg [17:0] wr_data_out
);
    reg single_q = 1'b1;
    wire k_late;
    assign k_clk_n_out = ~k_clk_out;
    assign #100 k_late = k_clk_out;
    // both high selects single clock mode
    assign c_clk_out = single_q | k_late;
    assign c_clk_n_out = single_q | ~k_late;
    initial begin
        k_clk_out = 1'b0;
        dll_off_n_out = 1'b1;
        load_strobe_n_out = 1'b1;
        read_write_sel_out = 1'b0;
        address_out = {AW{1'b0}};
        byte_write_sel_n_out = 2'b11;
        wr_data_out = 18'h00000;
        #7;
        forever #200 k_clk_out = ~k_clk_out;
    end
    // pins move at quarter periods, clear of both k edges
    task cmd(input rd, input ld_n, input [AW-1:0] a, input [17:0] w0, input [17:0] w1,
        input [1:0] b0, input [1:0] b1);
        begin
            @(posedge k_clk_n_out);
            #100;
            load_strobe_n_out = ld_n;
            read_write_sel_out = rd;
            address_out = a;
            @(posedge k_clk_out);
            #100;
            load_strobe_n_out = 1'b1;
            address_out = ~a;
            if (!rd) begin
                #200;
                wr_data_out = w0;
                byte_write_sel_n_out = b0;
                #200;
                wr_data_out = w1;
                byte_write_sel_n_out = b1;
                #200;
                wr_data_out = ~w1;
                byte_write_sel_n_out = 2'b11;
            end
        end
    endtask
endmodule // drsio_ctrl_model

// ### test/dual_rate_split_io_sram_port_bench.sv
// self-checking bench for the sram port core
`timescale 1ns/1ps
module dual_rate_split_io_sram_port_bench;
    localparam AW = 8;
    localparam [17:0] W0 = 18'h2a5a5;
    localparam [17:0] W1 = 18'h1c3c3;
    localparam [17:0] E0 = {W0[17:9], 9'h1ff};
    localparam [17:0] E1 = {9'h1ff, W1[8:0]};
    reg core_clk_in = 1'b0;
    reg nrst_in = 1'b0;
    wire k_clk_in, k_clk_n_in, c_clk_in, c_clk_n_in, dll_off_n_in;
    wire load_strobe_n_in, read_write_sel_in;
    wire [AW-1:0] address_in;
    wire [1:0] byte_write_sel_n_in;
    wire [17:0] wr_data_in, rd_data_out;
    wire rd_data_oe_out, echo_clock_pos_out, echo_clock_neg_out, impedance_cal_out;
    integer miscompares = 0;
    integer cmp_count = 0;
    initial forever #25 core_clk_in = ~core_clk_in;
    drsio_ctrl_model #(.AW(AW)) ctl (
        .k_clk_out(k_clk_in), .k_clk_n_out(k_clk_n_in), .c_clk_out(c_clk_in),
        .c_clk_n_out(c_clk_n_in), .dll_off_n_out(dll_off_n_in),
        .load_strobe_n_out(load_strobe_n_in), .read_write_sel_out(read_write_sel_in),
        .address_out(address_in), .byte_write_sel_n_out(byte_write_sel_n_in),
        .wr_data_out(wr_data_in)
    );
    // short cal period keeps the run brief
    drsio_port #(.AW(AW), .DW(18), .CAL_PERIOD(16)) dut (
        .core_clk_in, .nrst_in, .ce_in(1'b1), .k_clk_in, .k_clk_n_in, .c_clk_in,
        .c_clk_n_in, .dll_off_n_in, .load_strobe_n_in, .read_write_sel_in, .address_in,
        .byte_write_sel_n_in, .wr_data_in, .rd_data_out, .rd_data_oe_out,
        .echo_clock_pos_out, .echo_clock_neg_out, .impedance_cal_out
    );
    task results;
        begin
            if (miscompares == 0 && cmp_count > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task cmp(input [64:1] what, input [17:0] exp, input [17:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("ERROR %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wait_lvl(input sel, input lvl);
        integer n;
        begin
            n = 0;
            while (((sel ? echo_clock_neg_out : rd_data_oe_out) !== lvl) && n < 40) begin
                @(negedge core_clk_in);
                n = n + 1;
            end
            if ((sel ? echo_clock_neg_out : rd_data_oe_out) !== lvl) begin
                miscompares = miscompares + 1;
                results;
            end
        end
    endtask
    task cal_chk;
        integer n;
        begin
            n = 0;
            while (impedance_cal_out !== 1'b1 && n < 40) begin
                @(negedge core_clk_in);
                n = n + 1;
            end
            n = 1;
            @(negedge core_clk_in);
            while (impedance_cal_out !== 1'b1 && n < 40) begin
                @(negedge core_clk_in);
                n = n + 1;
            end
            cmp("cal_gap", 18'h00010, n[17:0]);
        end
    endtask
    task rd_chk(input [17:0] e0, input [17:0] e1);
        begin
            ctl.cmd(1'b1, 1'b0, 8'hff, 18'h00000, 18'h00000, 2'b11, 2'b11);
            wait_lvl(1'b0, 1'b1);
            cmp("word0", e0, rd_data_out);
            wait_lvl(1'b1, 1'b1);
            cmp("word1", e1, rd_data_out);
            wait_lvl(1'b0, 1'b0);
        end
    endtask
    initial begin
        repeat (4) @(negedge core_clk_in);
        cmp("oe_rst", 18'h00000, {17'h00000, rd_data_oe_out});
        cmp("echo_rst", 18'h00001, {17'h00000, echo_clock_neg_out & ~echo_clock_pos_out});
        nrst_in = 1'b1;
        repeat (4) @(negedge core_clk_in);
        ctl.cmd(1'b0, 1'b0, 8'hff, W0, W1, 2'b00, 2'b00);
        rd_chk(W0, W1);
        ctl.cmd(1'b0, 1'b0, 8'hff, 18'h3ffff, 18'h3ffff, 2'b10, 2'b11);
        ctl.cmd(1'b0, 1'b0, 8'hff, 18'h3ffff, 18'h3ffff, 2'b11, 2'b01);
        rd_chk(E0, E1);
        ctl.cmd(1'b0, 1'b1, 8'hff, 18'h00000, 18'h00000, 2'b00, 2'b00);
        rd_chk(E0, E1);
        @(negedge core_clk_in);
        ctl.single_q = 1'b0;
        ctl.dll_off_n_out = 1'b0;
        rd_chk(E0, E1);
        ctl.dll_off_n_out = 1'b1;
        rd_chk(E0, E1);
        cal_chk;
        results;
    end
endmodule // dual_rate_split_io_sram_port_bench
